// ===== hw/timer16_pkg.sv
// Package: register map, field layouts and constants of the 16-bit timer
package timer16_pkg;
    // ==========================================================
    // Register byte offsets on APB
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_CMP_A = 8'h0c;
    localparam logic [7:0] OFS_CMP_B = 8'h10;
    localparam logic [7:0] OFS_CAP_A = 8'h14;
    localparam logic [7:0] OFS_CAP_B = 8'h18;
    localparam logic [7:0] OFS_COUNT = 8'h1c;
    localparam logic [7:0] OFS_ALT_COUNT = 8'h20;
    // ==========================================================
    // Flag register bit positions
    localparam int FLG_CAP_A = 7;
    localparam int FLG_CMP_A = 6;
    localparam int FLG_OVF = 5;
    localparam int FLG_CAP_B = 4;
    localparam int FLG_CMP_B = 3;
    localparam int FLG_TIMER_OFF = 2;
    // Index of each event flag in the internal flag vector
    localparam int IX_CAP_A = 4;
    localparam int IX_CMP_A = 3;
    localparam int IX_OVF = 2;
    localparam int IX_CAP_B = 1;
    localparam int IX_CMP_B = 0;
    localparam int NUM_FLAGS = 5;
    // ==========================================================
    // Reset values and counter constants
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [15:0] COUNT_RELOAD = 16'hfffc;
    localparam logic [15:0] COUNT_TOP = 16'hffff;
    localparam logic [1:0] CLK_DIV4 = 2'b00;
    localparam logic [1:0] CLK_DIV2 = 2'b01;
    localparam logic [1:0] CLK_DIV8 = 2'b10;
    localparam logic [1:0] CLK_EXT = 2'b11;
    localparam logic [2:0] DIV2_LAST = 3'h1;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    // ==========================================================
    // Field layouts
    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic force_level_b;
        logic force_level_a;
        logic out_level_b;
        logic capture_edge_a;
        logic out_level_a;
    } ctrl1_t;
    typedef struct packed {
        logic pin_route_a;
        logic pin_route_b;
        logic one_pulse_select;
        logic pwm_select;
        logic [1:0] timer_clock_select;
        logic capture_edge_b;
        logic ext_clock_edge;
    } mode_ctrl_t;
    typedef struct packed {
        logic compare_out_pin_a;
        logic compare_out_en_a;
        logic compare_out_pin_b;
        logic compare_out_en_b;
    } compare_pins_t;
endpackage

// ===== hw/timer16_pwm_control.sv
// Module: 16-bit free-running timer with compare, capture, one-pulse and PWM
// ==========================================================
// Notes on behaviour
// - PWM: match A drives pin A level A
// - PWM: match B drives pin A level B
// - PWM: match B reloads counter with FFFCh
// - Level A 1, B 0: high A to B
// - Equal levels give constant pin A
// - Compare event at value plus five ticks
// - Tick is prescaled clock or external edge
// - PWM never sets compare flags
// - PWM: match B sets capture flag A
// - PWM: capture A disconnected, B still works
// - PWM wins over one-pulse select
// - Wait mode runs; enabled irq wakes
// - Halt freezes counter; resumes held value
// - Halt capture edge arms; flag at exit
// - One shared irq, enable and mask
// - Bits 7,6,5 enable capture, compare, overflow
// - Bit 4 forces level B onto pin B outside PWM/ONE_PULSE_SELECT
// - Bit 3 forces level A onto pin A outside PWM/ONE_PULSE_SELECT
// - Bit 2 at match B; pin A in PWM, at capture A edge in ONE_PULSE_SELECT
// - Bit 1 selects capture A edge
// - Bit 0 drives pin A at match A
// - PWM compare shadows load at period end
// - Clock select: div4, div2, div8, external
// - Pin A routing gated; compare keeps running
`timescale 1ns/1ps
`default_nettype none
module timer16_pwm_control
    import timer16_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_in_pin_a,
    input wire logic capture_in_pin_b,
    input wire logic ext_clock_pin,
    input wire logic wait_mode,
    input wire logic halt_mode,
    input wire logic cpu_irq_mask,
    output compare_pins_t compare_pins,
    output logic timer_irq,
    output logic wait_wake
);
    // ==========================================================
    // Decoding helpers
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CTRL1) || (a == OFS_MODE) || (a == OFS_FLAGS) || (a == OFS_CMP_A) ||
                 (a == OFS_CMP_B) || (a == OFS_CAP_A) || (a == OFS_CAP_B) || (a == OFS_COUNT) ||
                 (a == OFS_ALT_COUNT);
    endfunction
    function automatic logic [NUM_FLAGS-1:0] clear_target(input logic [7:0] a);
        clear_target = '0;
        clear_target[IX_CAP_A] = (a == OFS_CAP_A);
        clear_target[IX_CMP_A] = (a == OFS_CMP_A);
        clear_target[IX_OVF] = (a == OFS_COUNT);
        clear_target[IX_CAP_B] = (a == OFS_CAP_B);
        clear_target[IX_CMP_B] = (a == OFS_CMP_B);
    endfunction

    ctrl1_t ctrl1_r;
    mode_ctrl_t mode_r;
    logic timer_off_r;
    logic [15:0] cmp_a_r, cmp_b_r, shadow_a_r, shadow_b_r;
    logic [15:0] cap_a_r, cap_b_r, count_r;
    logic [NUM_FLAGS-1:0] flag_r, armed_r, flag_set, flag_clr;
    logic [2:0] presc_r;
    logic [2:0] sync_a_r, sync_b_r, sync_x_r;
    logic halt_d_r, arm_a_r, arm_b_r;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r;
    compare_pins_t pins_r;
    logic timer_irq_r, wait_wake_r;

    // ==========================================================
    // APB slave: setup cycle latches read data, access cycle completes
    logic setup_ph, done, wr_done, rd_done;
    assign setup_ph = psel && !penable;
    assign done = psel && penable && pready_r;
    assign wr_done = done && pwrite && mapped(paddr);
    assign rd_done = done && !pwrite && mapped(paddr);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_r <= setup_ph;
            pslverr_r <= setup_ph && !mapped(paddr);
            if (setup_ph && !pwrite) begin
                unique case (paddr)
                    OFS_CTRL1: prdata_r <= {24'h000000, ctrl1_r};
                    OFS_MODE: prdata_r <= {24'h000000, mode_r};
                    OFS_FLAGS: prdata_r <= {24'h000000, flag_r, timer_off_r, 2'b00};
                    OFS_CMP_A: prdata_r <= {16'h0000, cmp_a_r};
                    OFS_CMP_B: prdata_r <= {16'h0000, cmp_b_r};
                    OFS_CAP_A: prdata_r <= {16'h0000, cap_a_r};
                    OFS_CAP_B: prdata_r <= {16'h0000, cap_b_r};
                    OFS_COUNT: prdata_r <= {16'h0000, count_r};
                    OFS_ALT_COUNT: prdata_r <= {16'h0000, count_r};
                    default: prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl1_r <= CTRL1_RESET;
            mode_r <= MODE_RESET;
            timer_off_r <= 1'b0;
            cmp_a_r <= CMP_RESET;
            cmp_b_r <= CMP_RESET;
        end else if (clk_en && wr_done) begin
            if (paddr == OFS_CTRL1) ctrl1_r <= pwdata[7:0];
            if (paddr == OFS_MODE) mode_r <= pwdata[7:0];
            if (paddr == OFS_FLAGS) timer_off_r <= pwdata[FLG_TIMER_OFF];
            if (paddr == OFS_CMP_A) cmp_a_r <= pwdata[15:0];
            if (paddr == OFS_CMP_B) cmp_b_r <= pwdata[15:0];
        end
    end

    logic pwm_act, opm_act, normal_act;
    assign pwm_act = mode_r.pwm_select;
    assign opm_act = mode_r.one_pulse_select && !mode_r.pwm_select;
    assign normal_act = !mode_r.pwm_select && !mode_r.one_pulse_select;

    // ==========================================================
    // Input synchronisers and edge detection
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync_a_r <= 3'h0;
            sync_b_r <= 3'h0;
            sync_x_r <= 3'h0;
            halt_d_r <= 1'b0;
        end else if (clk_en) begin
            sync_a_r <= {sync_a_r[1:0], capture_in_pin_a};
            sync_b_r <= {sync_b_r[1:0], capture_in_pin_b};
            sync_x_r <= {sync_x_r[1:0], ext_clock_pin};
            halt_d_r <= halt_mode;
        end
    end

    logic edge_a, edge_b, edge_x, halt_exit;
    assign edge_a = ctrl1_r.capture_edge_a ? (sync_a_r[1] && !sync_a_r[2]) : (!sync_a_r[1] && sync_a_r[2]);
    assign edge_b = mode_r.capture_edge_b ? (sync_b_r[1] && !sync_b_r[2]) : (!sync_b_r[1] && sync_b_r[2]);
    assign edge_x = mode_r.ext_clock_edge ? (sync_x_r[1] && !sync_x_r[2]) : (!sync_x_r[1] && sync_x_r[2]);
    assign halt_exit = halt_d_r && !halt_mode;

    // ==========================================================
    // Prescaler and tick
    logic run_en, tick;
    logic [2:0] presc_last;
    assign run_en = !halt_mode && !timer_off_r;
    always_comb begin
        unique case (mode_r.timer_clock_select)
            CLK_DIV2: presc_last = DIV2_LAST;
            CLK_DIV8: presc_last = DIV8_LAST;
            default: presc_last = DIV4_LAST;
        endcase
    end
    assign tick = run_en && ((mode_r.timer_clock_select == CLK_EXT) ? edge_x : (presc_r == presc_last));

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            presc_r <= 3'h0;
        end else if (clk_en && run_en) begin
            presc_r <= (presc_r >= presc_last) ? 3'h0 : presc_r + 3'h1;
        end
    end

    // ==========================================================
    // Compare events: a tick while the counter equals the value
    logic hit_a, hit_b, cnt_wr, ovf_evt, cap_a_evt, cap_b_evt, opm_trig;
    assign hit_a = tick && (count_r == shadow_a_r);
    assign hit_b = tick && (count_r == shadow_b_r);
    assign cnt_wr = wr_done && ((paddr == OFS_COUNT) || (paddr == OFS_ALT_COUNT));
    assign opm_trig = opm_act && edge_a && !halt_mode;
    assign ovf_evt = tick && (count_r == COUNT_TOP) && !(pwm_act && hit_b);
    assign cap_a_evt = pwm_act ? hit_b : ((edge_a && !halt_mode) || (halt_exit && arm_a_r));
    assign cap_b_evt = (edge_b && !halt_mode) || (halt_exit && arm_b_r);

    // Shadows follow directly except in PWM, where they load at period end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            shadow_a_r <= CMP_RESET;
            shadow_b_r <= CMP_RESET;
        end else if (clk_en && (!pwm_act || hit_b)) begin
            shadow_a_r <= cmp_a_r;
            shadow_b_r <= cmp_b_r;
        end
    end

    // ==========================================================
    // Free-running counter
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_r <= COUNT_RELOAD;
        end else if (clk_en) begin
            if (cnt_wr || opm_trig || (pwm_act && hit_b)) count_r <= COUNT_RELOAD;
            else if (tick) count_r <= count_r + 16'h0001;
        end
    end

    // ==========================================================
    // Capture registers and halt arming
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cap_a_r <= 16'h0000;
            cap_b_r <= 16'h0000;
            arm_a_r <= 1'b0;
            arm_b_r <= 1'b0;
        end else if (clk_en) begin
            if (halt_mode && edge_a && !pwm_act) arm_a_r <= 1'b1;
            else if (!halt_mode) arm_a_r <= 1'b0;
            if (halt_mode && edge_b) arm_b_r <= 1'b1;
            else if (!halt_mode) arm_b_r <= 1'b0;
            if (cap_a_evt && !pwm_act) cap_a_r <= count_r;
            if (cap_b_evt) cap_b_r <= count_r;
        end
    end

    // ==========================================================
    // Event flags: set wins over clear
    always_comb begin
        flag_set = '0;
        flag_set[IX_CAP_A] = cap_a_evt;
        flag_set[IX_CMP_A] = hit_a && normal_act;
        flag_set[IX_OVF] = ovf_evt;
        flag_set[IX_CAP_B] = cap_b_evt;
        flag_set[IX_CMP_B] = hit_b && !pwm_act;
    end
    assign flag_clr = (done && mapped(paddr)) ? (clear_target(paddr) & armed_r) : '0;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    flag_r[gi] <= 1'b0;
                    armed_r[gi] <= 1'b0;
                end else if (clk_en) begin
                    if (flag_set[gi]) flag_r[gi] <= 1'b1;
                    else if (flag_clr[gi]) flag_r[gi] <= 1'b0;
                    if (rd_done && (paddr == OFS_FLAGS) && flag_r[gi]) armed_r[gi] <= 1'b1;
                    else if (flag_clr[gi]) armed_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Compare output pins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pins_r <= '0;
        end else if (clk_en) begin
            pins_r.compare_out_en_a <= mode_r.pin_route_a && !timer_off_r;
            pins_r.compare_out_en_b <= mode_r.pin_route_b && !timer_off_r;
            if (pwm_act) begin
                if (hit_b) pins_r.compare_out_pin_a <= ctrl1_r.out_level_b;
                else if (hit_a) pins_r.compare_out_pin_a <= ctrl1_r.out_level_a;
            end else if (opm_act) begin
                if (opm_trig) pins_r.compare_out_pin_a <= ctrl1_r.out_level_b;
                else if (hit_a) pins_r.compare_out_pin_a <= ctrl1_r.out_level_a;
            end else if (ctrl1_r.force_level_a || hit_a) begin
                pins_r.compare_out_pin_a <= ctrl1_r.out_level_a;
            end
            if (normal_act && (ctrl1_r.force_level_b || hit_b)) begin
                pins_r.compare_out_pin_b <= ctrl1_r.out_level_b;
            end
        end
    end

    // ==========================================================
    // Shared interrupt and wait wake-up
    logic irq_cond;
    assign irq_cond = !cpu_irq_mask &&
        ((ctrl1_r.capture_irq_enable && (flag_r[IX_CAP_A] || flag_r[IX_CAP_B])) ||
         (ctrl1_r.compare_irq_enable && (flag_r[IX_CMP_A] || flag_r[IX_CMP_B])) ||
         (ctrl1_r.overflow_irq_enable && flag_r[IX_OVF]));
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            timer_irq_r <= 1'b0;
            wait_wake_r <= 1'b0;
        end else if (clk_en) begin
            timer_irq_r <= irq_cond;
            wait_wake_r <= irq_cond && wait_mode && !halt_mode;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign compare_pins = pins_r;
    assign timer_irq = timer_irq_r;
    assign wait_wake = wait_wake_r;

    // ==========================================================
    // Assertions
    sequence s_pwm_end;
        clk_en && pwm_act && hit_b && !cnt_wr;
    endsequence
    sequence s_pwm_mid;
        clk_en && pwm_act && hit_a && !hit_b;
    endsequence
    AST_PWM_RELOAD: assert property (@(posedge clock) disable iff (!nrst)
        s_pwm_end |=> (count_r == COUNT_RELOAD)) else $error("PWM period end did not reload counter");
    AST_PWM_LEVEL_B: assert property (@(posedge clock) disable iff (!nrst)
        s_pwm_end |=> (pins_r.compare_out_pin_a == $past(ctrl1_r.out_level_b)))
        else $error("PWM match B level wrong");
    AST_PWM_LEVEL_A: assert property (@(posedge clock) disable iff (!nrst)
        s_pwm_mid |=> (pins_r.compare_out_pin_a == $past(ctrl1_r.out_level_a)))
        else $error("PWM match A level wrong");
    AST_PWM_CAP_FLAG: assert property (@(posedge clock) disable iff (!nrst)
        s_pwm_end |=> flag_r[IX_CAP_A]) else $error("PWM period end did not set capture flag");
    AST_PWM_NO_CMP_FLAG: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && pwm_act && !flag_r[IX_CMP_A] && !flag_r[IX_CMP_B] |=> !flag_r[IX_CMP_A] && !flag_r[IX_CMP_B])
        else $error("Compare flag set in PWM");
    AST_HALT_FREEZE: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && halt_mode && !cnt_wr |=> $stable(count_r)) else $error("Counter moved in halt");
    AST_PWM_CAP_A_HELD: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && pwm_act |=> $stable(cap_a_r)) else $error("Capture A loaded in PWM");
    AST_FORCE_A: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && normal_act && ctrl1_r.force_level_a |=> (pins_r.compare_out_pin_a == $past(ctrl1_r.out_level_a)))
        else $error("Forced level A not copied");
    AST_OVF_IRQ: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && !cpu_irq_mask && ctrl1_r.overflow_irq_enable && flag_r[IX_OVF] |=> timer_irq_r)
        else $error("Overflow interrupt missing");
    AST_DIV2_TICK: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && tick && (mode_r.timer_clock_select == CLK_DIV2) && $stable(mode_r) ##1 clk_en && run_en
        && $stable(mode_r) |-> !tick) else $error("Divide-by-two ticks back to back");
    sequence s_halt_wake_b;
        clk_en && halt_exit && arm_b_r;
    endsequence
    AST_PWM_SHADOW_HOLD: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && pwm_act && !hit_b |=> $stable(shadow_a_r) && $stable(shadow_b_r))
        else $error("Shadow moved mid-period");
    AST_HALT_CAP_B: assert property (@(posedge clock) disable iff (!nrst)
        s_halt_wake_b |=> flag_r[IX_CAP_B] && (cap_b_r == $past(count_r)))
        else $error("Halt capture B lost");
    AST_HALT_NO_WAKE: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && halt_mode |=> !wait_wake_r)
        else $error("Wake raised in halt");
    AST_WAIT_WAKE: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && irq_cond && wait_mode && !halt_mode |=> wait_wake_r)
        else $error("Wait wake missing");
    AST_MATCH_A_LEVEL: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && normal_act && hit_a |=> (pins_r.compare_out_pin_a == $past(ctrl1_r.out_level_a)))
        else $error("Match A level wrong");
    AST_FORCE_B: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && normal_act && ctrl1_r.force_level_b |=> (pins_r.compare_out_pin_b == $past(ctrl1_r.out_level_b)))
        else $error("Forced level B not copied");
    AST_ROUTE_A: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && !mode_r.pin_route_a |=> !pins_r.compare_out_en_a)
        else $error("Pin A enabled without routing");
    AST_CAP_IRQ: assert property (@(posedge clock) disable iff (!nrst)
        clk_en && !cpu_irq_mask && ctrl1_r.capture_irq_enable && flag_r[IX_CAP_B] |=> timer_irq_r)
        else $error("Capture interrupt missing");
endmodule
`default_nettype wire

// ===== testbench/timer16_far_side.sv
// Far-side model: capture pin drivers and external tick source
`timescale 1ns/1ps
`default_nettype none
module timer16_far_side (
    input wire logic clock,
    input wire logic ext_run,
    input wire logic cap_low_a,
    input wire logic cap_low_b,
    output logic capture_in_pin_a,
    output logic capture_in_pin_b,
    output logic ext_clock_pin
);
    // ==========================================================
    // Capture pins idle high; tick source stands still unless run
    logic [1:0] div_r;
    initial begin
        div_r = 2'b00;
        capture_in_pin_a = 1'b1;
        capture_in_pin_b = 1'b1;
        ext_clock_pin = 1'b0;
    end
    always @(posedge clock) begin
        capture_in_pin_a <= !cap_low_a;
        capture_in_pin_b <= !cap_low_b;
        if (ext_run) begin
            div_r <= div_r + 2'd1;
        end
        ext_clock_pin <= div_r[1];
    end
endmodule
`default_nettype wire

// ===== testbench/timer16_pwm_control_tb.sv
// Testbench: PWM timing, flags, irq, force, halt and reset of the timer
`timescale 1ns/1ps
`default_nettype none
`define check_eq(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (got), (exp)); \
        end \
    end
module timer16_pwm_control_tb
    import timer16_pkg::*;
;
    // ==========================================================
    // Signals
    logic clock = 1'b0;
    logic nrst, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic rerr, wait_mode, halt_mode, cpu_irq_mask, timer_irq, wait_wake;
    logic ext_run, cap_low_a, cap_low_b;
    logic [15:0] held;
    wire logic capture_in_pin_a, capture_in_pin_b, ext_clock_pin;
    compare_pins_t compare_pins;
    int errors = 0;
    int tests_run = 0;
    typedef struct {logic [7:0] mode; logic [7:0] ctl; int hi; int per;} pwm_row_t;
    // Compare A = 3, B = 9: pin A at level A from match A to match B for (9-3)*div, period (9+5)*div
    pwm_row_t rows[6] = '{'{8'h94, 8'h01, 12, 28}, '{8'h90, 8'h01, 24, 56}, '{8'h98, 8'h01, 48, 112},
        '{8'hb4, 8'h01, 12, 28}, '{8'h9d, 8'h01, 24, 56}, '{8'h94, 8'h04, 16, 28}};
    always #12.5 clock = ~clock;
    timer16_pwm_control u_dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_in_pin_a(capture_in_pin_a),
        .capture_in_pin_b(capture_in_pin_b), .ext_clock_pin(ext_clock_pin), .wait_mode(wait_mode),
        .halt_mode(halt_mode), .cpu_irq_mask(cpu_irq_mask), .compare_pins(compare_pins),
        .timer_irq(timer_irq), .wait_wake(wait_wake));
    timer16_far_side u_far (.clock(clock), .ext_run(ext_run), .cap_low_a(cap_low_a),
        .cap_low_b(cap_low_b), .capture_in_pin_a(capture_in_pin_a),
        .capture_in_pin_b(capture_in_pin_b), .ext_clock_pin(ext_clock_pin));
    // ==========================================================
    // Bus and measurement tasks
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) errors++;
    endtask
    task automatic run_len(input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (compare_pins.compare_out_pin_a === lvl && n < 400);
    endtask
    task automatic end_sim();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        end_sim();
    end
    // ==========================================================
    // Main sequence
    initial begin
        int hi, lo, n;
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {wait_mode, halt_mode, cpu_irq_mask, ext_run, cap_low_a, cap_low_b} = '0;
        clk_en = 1'b1;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        `check_eq(compare_pins, 4'h0)
        apb(1'b0, OFS_CTRL1, 32'h0);
        `check_eq(rdata, 32'h0)
        apb(1'b0, OFS_CMP_A, 32'h0);
        `check_eq(rdata[15:0], 16'h8000)
        apb(1'b0, 8'h24, 32'h0);
        `check_eq(rerr, 1'b1)
        apb(1'b1, OFS_CMP_A, 32'h3);
        apb(1'b1, OFS_CMP_B, 32'h9);
        for (int i = 0; i < 6; i++) begin
            ext_run <= (rows[i].mode[3:2] == 2'b11);
            apb(1'b1, OFS_CTRL1, {24'h0, rows[i].ctl});
            apb(1'b1, OFS_MODE, {24'h0, rows[i].mode});
            apb(1'b1, OFS_COUNT, 32'h0);
            run_len(1'b1, n);
            run_len(1'b0, n);
            run_len(1'b1, hi);
            run_len(1'b0, lo);
            `check_eq(hi, rows[i].hi)
            `check_eq(hi + lo, rows[i].per)
        end
        ext_run <= 1'b0;
        apb(1'b0, OFS_FLAGS, 32'h0);
        `check_eq(rdata[7], 1'b1)
        `check_eq({rdata[6], rdata[3]}, 2'b00)
        // Shared interrupt, enables, mask and wait wake-up
        apb(1'b1, OFS_CTRL1, 32'h81);
        repeat (40) @(posedge clock);
        `check_eq(timer_irq, 1'b1)
        wait_mode <= 1'b1;
        repeat (3) @(posedge clock);
        `check_eq(wait_wake, 1'b1)
        cpu_irq_mask <= 1'b1;
        repeat (3) @(posedge clock);
        `check_eq(timer_irq, 1'b0)
        cpu_irq_mask <= 1'b0;
        wait_mode <= 1'b0;
        apb(1'b1, OFS_CTRL1, 32'h41);
        repeat (40) @(posedge clock);
        `check_eq(timer_irq, 1'b0)
        // Equal levels hold pin A constant
        apb(1'b1, OFS_CTRL1, 32'h05);
        apb(1'b1, OFS_CMP_A, 32'h5);
        apb(1'b1, OFS_CMP_A, 32'h3);
        repeat (3) @(posedge clock);
        n = 0;
        repeat (100) begin
            @(posedge clock);
            n += (compare_pins.compare_out_pin_a !== 1'b1);
        end
        `check_eq(n, 0)
        // Capture A is disconnected in PWM, capture B still works
        cap_low_a <= 1'b1;
        cap_low_b <= 1'b1;
        repeat (6) @(posedge clock);
        cap_low_a <= 1'b0;
        cap_low_b <= 1'b0;
        repeat (6) @(posedge clock);
        apb(1'b0, OFS_CAP_A, 32'h0);
        `check_eq(rdata, 32'h0)
        apb(1'b0, OFS_FLAGS, 32'h0);
        `check_eq(rdata[4], 1'b1)
        apb(1'b0, OFS_CAP_B, 32'h0);
        apb(1'b0, OFS_FLAGS, 32'h0);
        `check_eq(rdata[4], 1'b0)
        // Forced levels and pin routing
        apb(1'b1, OFS_MODE, 32'hc0);
        apb(1'b1, OFS_CTRL1, 32'h1c);
        repeat (4) @(posedge clock);
        `check_eq(compare_pins, 4'h7)
        apb(1'b1, OFS_MODE, 32'h40);
        repeat (4) @(posedge clock);
        `check_eq(compare_pins.compare_out_en_a, 1'b0)
        // One-pulse mode: a rising capture A edge starts a level B pulse
        apb(1'b1, OFS_CTRL1, 32'h06);
        apb(1'b1, OFS_MODE, 32'ha4);
        cap_low_a <= 1'b1;
        repeat (8) @(posedge clock);
        `check_eq(compare_pins.compare_out_pin_a, 1'b0)
        cap_low_a <= 1'b0;
        run_len(1'b0, n);
        run_len(1'b1, hi);
        `check_eq(hi == 15 || hi == 16, 1'b1)
        // Halt freezes the counter and arms capture B
        apb(1'b1, OFS_MODE, 32'h06);
        apb(1'b1, OFS_CTRL1, 32'h0);
        apb(1'b1, OFS_COUNT, 32'h0);
        halt_mode <= 1'b1;
        repeat (4) @(posedge clock);
        apb(1'b0, OFS_COUNT, 32'h0);
        held = rdata[15:0];
        cap_low_b <= 1'b1;
        repeat (4) @(posedge clock);
        cap_low_b <= 1'b0;
        repeat (20) @(posedge clock);
        apb(1'b0, OFS_COUNT, 32'h0);
        `check_eq(rdata[15:0], held)
        halt_mode <= 1'b0;
        repeat (4) @(posedge clock);
        apb(1'b0, OFS_FLAGS, 32'h0);
        `check_eq(rdata[4], 1'b1)
        apb(1'b0, OFS_CAP_B, 32'h0);
        `check_eq(rdata[15:0], held)
        apb(1'b0, OFS_COUNT, 32'h0);
        `check_eq((rdata[15:0] - held) < 16'd40 && rdata[15:0] !== held, 1'b1)
        // Reset in mid-run restores the reset values
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        apb(1'b0, OFS_CTRL1, 32'h0);
        `check_eq(rdata, 32'h0)
        apb(1'b0, OFS_COUNT, 32'h0);
        `check_eq(rdata[15:2], 14'h3fff)
        // Clock enable low freezes the counter
        clk_en <= 1'b0;
        repeat (20) @(posedge clock);
        clk_en <= 1'b1;
        apb(1'b0, OFS_COUNT, 32'h0);
        `check_eq(rdata[15:2], 14'h3fff)
        end_sim();
    end
endmodule
`default_nettype wire
